// *** src/rsdr_top.sv ***
// Reader status display registers: regulator/timer, peak signal strength and gain reduction.
// Assumes all status inputs come from logic on clk_sys_in; no synchronisers are needed.
// Function
// - Regulator/timer display bits 7..4 show the regulated voltage code in effect.
// - Reset and set-default force the regulated voltage code to all ones.
// - Bit 2 shows the general purpose timer running.
// - Bit 1 shows the no-response timer running.
// - Bit 0 shows the mask-receive timer running.
// - Strength display bits 7..4 hold the amplitude channel peak code.
// - Strength display bits 3..0 hold the phase channel peak code.
// - Both peaks clear at message start and on the clear-strength command.
// - Strength codes are 4-bit monotonic, zero at or below the lowest threshold.
// - The channel-select bit picks which strength value feeds internal logic.
// - Strength and gain reduction registers read zero after reset and set-default.
// - Gain reduction bits 7..4 show amplitude channel second-stage reduction, bit 7 MSB.
// - Gain reduction bits 3..0 show phase channel second-stage reduction, bit 3 MSB.
// - Channel-select bit reads 0 for amplitude, 1 for phase.
// - Source bit 0 takes the adjust result, 1 takes the externally written code.
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/10ps
module rsdr_top
  import rsdr_pkg::*;
(
  input  wire logic       clk_sys_in,
  input  wire logic       rst_n_in,
  input  wire logic       clk_en_in,
  input  wire logic       set_default_in,
  input  wire logic       clear_strength_in,
  input  wire logic       msg_start_in,
  input  wire logic       reg_src_sel_in,
  input  wire rsdr_code_t reg_ext_code_in,
  input  wire logic       reg_adj_done_in,
  input  wire rsdr_code_t reg_adj_code_in,
  input  wire logic       gpt_running_in,
  input  wire logic       nrt_running_in,
  input  wire logic       mrt_running_in,
  input  wire logic       strength_valid_in,
  input  wire rsdr_code_t amp_strength_in,
  input  wire rsdr_code_t phase_strength_in,
  input  wire logic       phase_chan_sel_in,
  input  wire rsdr_code_t amp_gain_cut_in,
  input  wire rsdr_code_t phase_gain_cut_in,
  input  wire rsdr_addr_t addr_in,
  input  wire rsdr_data_t wdata_in,
  input  wire logic       wr_in,
  input  wire logic       rd_in,
  output rsdr_data_t      rdata_out,
  output rsdr_code_t      reg_code_out,
  output rsdr_code_t      strength_for_logic_out,
  output logic            chan_sel_bit_out
);
  rsdr_rd_if rd_bus ();

  // Regulator code: adjust result, held until the next adjust or set-default
  rsdr_code_t adj_code;
  rsdr_code_t next_adj_code;
  logic       src_sel;
  logic       next_src_sel;
  rsdr_code_t ext_code;
  rsdr_code_t next_ext_code;
  rsdr_code_t reg_code;

  always_comb begin
    next_adj_code = adj_code;
    next_src_sel  = reg_src_sel_in;
    next_ext_code = reg_ext_code_in;
    if (set_default_in) begin
      next_adj_code = REG_CODE_MAX;
      next_src_sel  = SRC_ADJUST;
      next_ext_code = CODE_ZERO;
    end else if (reg_adj_done_in) begin
      next_adj_code = reg_adj_code_in;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      adj_code <= REG_CODE_MAX;
      src_sel  <= SRC_ADJUST;
      ext_code <= CODE_ZERO;
    end else if (clk_en_in) begin
      adj_code <= next_adj_code;
      src_sel  <= next_src_sel;
      ext_code <= next_ext_code;
    end
  end

  assign reg_code = (src_sel == SRC_ADJUST) ? adj_code : ext_code;

  // Timer running flags, registered so the readback is glitch free
  logic gpt_on;
  logic nrt_on;
  logic mrt_on;
  logic next_gpt_on;
  logic next_nrt_on;
  logic next_mrt_on;

  always_comb begin
    next_gpt_on = gpt_running_in;
    next_nrt_on = nrt_running_in;
    next_mrt_on = mrt_running_in;
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      gpt_on <= 1'b0;
      nrt_on <= 1'b0;
      mrt_on <= 1'b0;
    end else if (clk_en_in) begin
      gpt_on <= next_gpt_on;
      nrt_on <= next_nrt_on;
      mrt_on <= next_mrt_on;
    end
  end

  // Peak hold; set-default clears like a message start
  logic       peak_clear;
  rsdr_code_t amp_peak;
  rsdr_code_t phase_peak;

  assign peak_clear = msg_start_in | clear_strength_in | set_default_in;

  // Codes arrive already in the monotonic 4-bit form, so plain compare keeps the maximum
  rsdr_peak_hold u_amp_peak (
    .clk_sys_in (clk_sys_in),
    .rst_n_in   (rst_n_in),
    .clk_en_in  (clk_en_in),
    .clear_in   (peak_clear),
    .valid_in   (strength_valid_in),
    .code_in    (amp_strength_in),
    .peak_out   (amp_peak)
  );

  rsdr_peak_hold u_phase_peak (
    .clk_sys_in (clk_sys_in),
    .rst_n_in   (rst_n_in),
    .clk_en_in  (clk_en_in),
    .clear_in   (peak_clear),
    .valid_in   (strength_valid_in),
    .code_in    (phase_strength_in),
    .peak_out   (phase_peak)
  );

  // Gain reduction state and channel select
  rsdr_code_t amp_cut;
  rsdr_code_t phase_cut;
  rsdr_code_t next_amp_cut;
  rsdr_code_t next_phase_cut;
  logic       chan_sel;
  logic       next_chan_sel;

  always_comb begin
    next_amp_cut   = amp_gain_cut_in;
    next_phase_cut = phase_gain_cut_in;
    next_chan_sel  = phase_chan_sel_in;
    if (set_default_in) begin
      next_amp_cut   = CODE_ZERO;
      next_phase_cut = CODE_ZERO;
      next_chan_sel  = CHAN_AMP;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      amp_cut   <= CODE_ZERO;
      phase_cut <= CODE_ZERO;
      chan_sel  <= CHAN_AMP;
    end else if (clk_en_in) begin
      amp_cut   <= next_amp_cut;
      phase_cut <= next_phase_cut;
      chan_sel  <= next_chan_sel;
    end
  end

  // Register images; writes have no path into any of them
  rsdr_data_t reg_timer_img;

  always_comb begin
    reg_timer_img                              = DATA_ZERO;
    reg_timer_img[POS_REG_CODE_LSB +: CODE_W]  = reg_code;
    reg_timer_img[POS_GPT_ON]                  = gpt_on;
    reg_timer_img[POS_NRT_ON]                  = nrt_on;
    reg_timer_img[POS_MRT_ON]                  = mrt_on;
  end

  assign rd_bus.addr      = addr_in;
  assign rd_bus.rd        = rd_in;
  assign rd_bus.reg_timer = reg_timer_img;
  assign rd_bus.strength  = rsdr_pack(amp_peak, phase_peak);
  assign rd_bus.gain_cut  = rsdr_pack(amp_cut, phase_cut);

  rsdr_read_port u_read_port (
    .clk_sys_in (clk_sys_in),
    .rst_n_in   (rst_n_in),
    .clk_en_in  (clk_en_in),
    .bus        (rd_bus)
  );

  // Write strobe and data are accepted and dropped
  logic unused_wr;
  assign unused_wr = wr_in | (|wdata_in);

  assign rdata_out              = rd_bus.rdata;
  assign reg_code_out           = reg_code;
  assign strength_for_logic_out = (chan_sel == CHAN_AMP) ? amp_peak : phase_peak;
  assign chan_sel_bit_out       = chan_sel;
endmodule : rsdr_top

// *** src/rsdr_pkg.sv ***
// Constants, field layout and helper functions of the reader status display registers.
// Assumes nothing outside; every other design file imports it whole.
package rsdr_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned CODE_W = 4;

  typedef logic [ADDR_W-1:0] rsdr_addr_t;
  typedef logic [DATA_W-1:0] rsdr_data_t;
  typedef logic [CODE_W-1:0] rsdr_code_t;

  // Register byte offsets
  localparam rsdr_addr_t OFS_REGULATOR_TIMER_DISPLAY = 8'h2b;
  localparam rsdr_addr_t OFS_SIGNAL_STRENGTH_DISPLAY = 8'h2c;
  localparam rsdr_addr_t OFS_GAIN_REDUCTION_STATE    = 8'h2d;

  // Field positions
  localparam int unsigned POS_REG_CODE_LSB = 4;
  localparam int unsigned POS_GPT_ON       = 2;
  localparam int unsigned POS_NRT_ON       = 1;
  localparam int unsigned POS_MRT_ON       = 0;
  localparam int unsigned POS_AMP_LSB      = 4;
  localparam int unsigned POS_PHASE_LSB    = 0;

  // Reset values
  localparam rsdr_code_t REG_CODE_MAX   = 4'hf;
  localparam rsdr_code_t CODE_ZERO      = 4'h0;
  localparam rsdr_data_t DATA_ZERO      = 8'h00;
  localparam logic       SRC_ADJUST     = 1'b0;
  localparam logic       CHAN_AMP       = 1'b0;

  // Places two 4-bit codes side by side in a byte
  function automatic rsdr_data_t rsdr_pack(input rsdr_code_t hi, input rsdr_code_t lo);
    rsdr_data_t d;
    d = DATA_ZERO;
    d[POS_AMP_LSB +: CODE_W]   = hi;
    d[POS_PHASE_LSB +: CODE_W] = lo;
    return d;
  endfunction : rsdr_pack

  // True when a fresh code beats the held peak
  function automatic logic rsdr_beats(input rsdr_code_t fresh, input rsdr_code_t held);
    return fresh > held;
  endfunction : rsdr_beats
endpackage : rsdr_pkg

// *** src/rsdr_rd_if.sv ***
// Read path between the register holder and the read-data port.
// Assumes one clock shared by both ends.
`timescale 1ns/10ps
interface rsdr_rd_if;
  import rsdr_pkg::*;
  rsdr_addr_t addr;
  logic       rd;
  rsdr_data_t reg_timer;
  rsdr_data_t strength;
  rsdr_data_t gain_cut;
  rsdr_data_t rdata;
  modport holder (output addr, output rd, output reg_timer, output strength, output gain_cut, input rdata);
  modport port   (input addr, input rd, input reg_timer, input strength, input gain_cut, output rdata);
endinterface : rsdr_rd_if

// *** src/rsdr_peak_hold.sv ***
// One 4-bit peak-hold field.
// Assumes clear and valid are one-cycle pulses from logic on the same clock.
`timescale 1ns/10ps
module rsdr_peak_hold
  import rsdr_pkg::*;
(
  input  wire logic       clk_sys_in,
  input  wire logic       rst_n_in,
  input  wire logic       clk_en_in,
  input  wire logic       clear_in,
  input  wire logic       valid_in,
  input  wire rsdr_code_t code_in,
  output rsdr_code_t      peak_out
);
  rsdr_code_t peak;
  rsdr_code_t next_peak;

  always_comb begin
    next_peak = peak;
    if (clear_in) begin
      next_peak = CODE_ZERO;
    end else if (valid_in && rsdr_beats(code_in, peak)) begin
      next_peak = code_in;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      peak <= CODE_ZERO;
    end else if (clk_en_in) begin
      peak <= next_peak;
    end
  end

  assign peak_out = peak;
endmodule : rsdr_peak_hold

// *** src/rsdr_read_port.sv ***
// Read-data register: answers a read strobe one cycle later.
// Assumes the holder drives the register images from flip-flops.
`timescale 1ns/10ps
module rsdr_read_port
  import rsdr_pkg::*;
(
  input  wire logic clk_sys_in,
  input  wire logic rst_n_in,
  input  wire logic clk_en_in,
  rsdr_rd_if.port   bus
);
  rsdr_data_t rdata;
  rsdr_data_t next_rdata;

  always_comb begin
    next_rdata = DATA_ZERO;
    if (bus.rd) begin
      unique case (bus.addr)
        OFS_REGULATOR_TIMER_DISPLAY: next_rdata = bus.reg_timer;
        OFS_SIGNAL_STRENGTH_DISPLAY: next_rdata = bus.strength;
        OFS_GAIN_REDUCTION_STATE:    next_rdata = bus.gain_cut;
        default:                     next_rdata = DATA_ZERO;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      rdata <= DATA_ZERO;
    end else if (clk_en_in) begin
      rdata <= next_rdata;
    end
  end

  assign bus.rdata = rdata;
endmodule : rsdr_read_port

// *** testbench/rsdr_props.sv ***
// Port-level assertions for the status display registers.
// Assumes binding onto rsdr_top; one clock, synchronous reset.
`timescale 1ns/10ps
module rsdr_props
  import rsdr_pkg::*;
(
  input wire logic       clk_sys_in,
  input wire logic       rst_n_in,
  input wire logic       clk_en_in,
  input wire logic       set_default_in,
  input wire logic       clear_strength_in,
  input wire logic       msg_start_in,
  input wire logic       reg_src_sel_in,
  input wire rsdr_code_t reg_ext_code_in,
  input wire logic       gpt_running_in,
  input wire logic       nrt_running_in,
  input wire logic       mrt_running_in,
  input wire logic       phase_chan_sel_in,
  input wire rsdr_code_t amp_gain_cut_in,
  input wire rsdr_code_t phase_gain_cut_in,
  input wire rsdr_addr_t addr_in,
  input wire logic       rd_in,
  input wire rsdr_data_t rdata_out,
  input wire rsdr_code_t reg_code_out,
  input wire rsdr_code_t strength_for_logic_out,
  input wire logic       chan_sel_bit_out
);
  default clocking dc @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);

  chk_idle_read_zero: assert property (clk_en_in && !rd_in |=> rdata_out == DATA_ZERO)
    else $error("read data not zero when idle");
  chk_timer_bits: assert property (clk_en_in && rd_in && addr_in == OFS_REGULATOR_TIMER_DISPLAY
    && $past(clk_en_in && rst_n_in) |=> rdata_out[3:0] == {1'h0, $past({gpt_running_in,
    nrt_running_in, mrt_running_in}, 2)} && rdata_out[7:4] == $past(reg_code_out))
    else $error("regulator and timer image wrong");
  chk_gain_image: assert property (clk_en_in && rd_in && addr_in == OFS_GAIN_REDUCTION_STATE
    && $past(clk_en_in && rst_n_in && !set_default_in)
    |=> rdata_out == $past({amp_gain_cut_in, phase_gain_cut_in}, 2))
    else $error("gain reduction image wrong");
  chk_peak_image: assert property (clk_en_in && rd_in && addr_in == OFS_SIGNAL_STRENGTH_DISPLAY
    |=> $past(strength_for_logic_out) == ($past(chan_sel_bit_out) ? rdata_out[3:0] : rdata_out[7:4]))
    else $error("strength image disagrees with selected peak");
  chk_unmapped_zero: assert property (clk_en_in && rd_in
    && (addr_in < OFS_REGULATOR_TIMER_DISPLAY || addr_in > OFS_GAIN_REDUCTION_STATE)
    |=> rdata_out == DATA_ZERO)
    else $error("unmapped read not zero");
  chk_ext_code: assert property (clk_en_in && reg_src_sel_in && !set_default_in
    |=> reg_code_out == $past(reg_ext_code_in))
    else $error("external regulator code not in effect");
  chk_set_default: assert property (set_default_in && clk_en_in
    |=> reg_code_out == REG_CODE_MAX && strength_for_logic_out == CODE_ZERO && !chan_sel_bit_out)
    else $error("set-default values wrong");
  chk_peak_clear: assert property ((msg_start_in || clear_strength_in) && clk_en_in
    |=> strength_for_logic_out == CODE_ZERO)
    else $error("peak not cleared");
  chk_peak_keeps_max: assert property (clk_en_in && !clear_strength_in && !msg_start_in
    && !set_default_in && phase_chan_sel_in == chan_sel_bit_out
    |=> strength_for_logic_out >= $past(strength_for_logic_out))
    else $error("peak fell without a clear");
endmodule : rsdr_props

bind rsdr_top rsdr_props u_props (.*);

// *** testbench/tb_top.sv ***
// Self-checking bench for the status display registers.
// Assumes rsdr_pkg and rsdr_top; the bench drives every port itself.
`timescale 1ns/10ps
module tb_top;
  import rsdr_pkg::*;
  logic       clk_sys_in, rst_n_in, clk_en_in, set_default_in, clear_strength_in, msg_start_in;
  logic       reg_src_sel_in, reg_adj_done_in, gpt_running_in, nrt_running_in, mrt_running_in;
  logic       strength_valid_in, phase_chan_sel_in, wr_in, rd_in, chan_sel_bit_out;
  rsdr_code_t reg_ext_code_in, reg_adj_code_in, amp_strength_in, phase_strength_in;
  rsdr_code_t amp_gain_cut_in, phase_gain_cut_in, reg_code_out, strength_for_logic_out;
  rsdr_addr_t addr_in;
  rsdr_data_t wdata_in, rdata_out;
  int         err_total, total_checks, cyc;

  rsdr_top dut (.*);

  initial begin
    clk_sys_in = 1'h0;
    forever #25 clk_sys_in = ~clk_sys_in;
  end

  task automatic chk(input string n, input rsdr_data_t s, input rsdr_data_t e);
    total_checks++;
    if (s !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  // Read data is looked at only in the one cycle it stands
  task automatic rd(input rsdr_addr_t a, input rsdr_data_t e);
    @(posedge clk_sys_in);
    rd_in   <= 1'h1;
    addr_in <= a;
    @(posedge clk_sys_in);
    rd_in <= 1'h0;
    #1 chk($sformatf("reg %h", a), rdata_out, e);
  endtask : rd

  // One-cycle write strobe; the display registers must ignore it
  task automatic wr(input rsdr_addr_t a, input rsdr_data_t d);
    @(posedge clk_sys_in);
    wr_in    <= 1'h1;
    addr_in  <= a;
    wdata_in <= d;
    @(posedge clk_sys_in);
    wr_in <= 1'h0;
  endtask : wr

  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : final_report

  always @(posedge clk_sys_in) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      final_report;
    end
  end

  initial begin
    {rst_n_in, set_default_in, clear_strength_in, msg_start_in, reg_src_sel_in, reg_adj_done_in} = '0;
    {gpt_running_in, nrt_running_in, mrt_running_in, strength_valid_in, phase_chan_sel_in} = '0;
    {reg_ext_code_in, reg_adj_code_in, amp_strength_in, phase_strength_in} = '0;
    {amp_gain_cut_in, phase_gain_cut_in, addr_in, wdata_in, wr_in, rd_in} = '0;
    clk_en_in = 1'h1;
    cyc = 0;
    repeat (4) @(posedge clk_sys_in);
    rst_n_in <= 1'h1;
    rd(OFS_REGULATOR_TIMER_DISPLAY, 8'hf0);
    rd(OFS_SIGNAL_STRENGTH_DISPLAY, 8'h00);
    rd(OFS_GAIN_REDUCTION_STATE, 8'h00);
    for (int i = 0; i < 8; i++) begin
      {gpt_running_in, nrt_running_in, mrt_running_in} <= i[2:0];
      rd(OFS_REGULATOR_TIMER_DISPLAY, {5'h1e, i[2:0]});
    end
    reg_src_sel_in  <= 1'h1;
    reg_ext_code_in <= 4'h5;
    rd(OFS_REGULATOR_TIMER_DISPLAY, 8'h57);
    reg_src_sel_in  <= 1'h0;
    reg_adj_code_in <= 4'h9;
    reg_adj_done_in <= 1'h1;
    @(posedge clk_sys_in);
    reg_adj_done_in <= 1'h0;
    rd(OFS_REGULATOR_TIMER_DISPLAY, 8'h97);
    amp_gain_cut_in   <= 4'h3;
    phase_gain_cut_in <= 4'hc;
    rd(OFS_GAIN_REDUCTION_STATE, 8'h3c);
    // Second measurement is smaller on one channel, larger on the other
    {amp_strength_in, phase_strength_in, strength_valid_in} <= {8'h52, 1'h1};
    @(posedge clk_sys_in);
    {amp_strength_in, phase_strength_in} <= 8'h37;
    @(posedge clk_sys_in);
    strength_valid_in <= 1'h0;
    rd(OFS_SIGNAL_STRENGTH_DISPLAY, 8'h57);
    wr(OFS_SIGNAL_STRENGTH_DISPLAY, 8'hff);
    wr(OFS_REGULATOR_TIMER_DISPLAY, 8'h00);
    wr(OFS_GAIN_REDUCTION_STATE, 8'hff);
    rd(OFS_REGULATOR_TIMER_DISPLAY, 8'h97);
    rd(OFS_GAIN_REDUCTION_STATE, 8'h3c);
    rd(OFS_SIGNAL_STRENGTH_DISPLAY, 8'h57);
    // Enable low must hold the standing read data and ignore a larger measurement
    clk_en_in <= 1'h0;
    {amp_strength_in, phase_strength_in, strength_valid_in} <= {8'hff, 1'h1};
    repeat (2) @(posedge clk_sys_in);
    #1 chk("frozen", rdata_out, 8'h57);
    clk_en_in         <= 1'h1;
    strength_valid_in <= 1'h0;
    rd(OFS_SIGNAL_STRENGTH_DISPLAY, 8'h57);
    phase_chan_sel_in <= 1'h1;
    repeat (2) @(posedge clk_sys_in);
    #1 chk("select", {3'h0, chan_sel_bit_out, strength_for_logic_out}, 8'h17);
    for (int j = 0; j < 2; j++) begin
      {msg_start_in, clear_strength_in} <= 2'(j + 1);
      @(posedge clk_sys_in);
      {msg_start_in, clear_strength_in} <= 2'h0;
      rd(OFS_SIGNAL_STRENGTH_DISPLAY, 8'h00);
      strength_valid_in <= 1'h1;
      @(posedge clk_sys_in);
      strength_valid_in <= 1'h0;
    end
    rd(8'h2e, 8'h00);
    set_default_in <= 1'h1;
    @(posedge clk_sys_in);
    set_default_in <= 1'h0;
    #1 chk("code", {4'h0, reg_code_out}, 8'h0f);
    rd(OFS_SIGNAL_STRENGTH_DISPLAY, 8'h00);
    final_report;
  end
endmodule : tb_top
